// >>> pwco_host_model.sv
// Host microcontroller model for the register port
`timescale 1ns/1ps
`default_nettype none
module pwco_host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [7:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial {regAddr, regWrite, regRead, regWdata} = 18'h00000;
  // Released lines carry junk so stale values are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    {regAddr, regWdata, regWrite} = {a, d, 1'b1};
    @(posedge mclk) #1;
    {regAddr, regWdata, regWrite} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    {regAddr, regRead} = {a, 1'b1};
    @(posedge mclk) #1;
    {regAddr, regRead} = {~a, 1'b0};
    @(posedge mclk) #1;
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// >>> pwco_monitor.sv
// Assertion checker for the polling wake block
`timescale 1ns/1ps
`default_nettype none
module pwco_monitor (
  // Clock, reset, strobes and status
  input wire logic mclk,
  input wire logic rstn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic pollTimerEn,
  // Register data
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  // Outputs under watch
  input wire logic oscEnable,
  input wire logic extBufEnable,
  input wire logic refClkAlways,
  input wire logic pollIrq,
  input wire logic rxLaunch,
  input wire logic rxFlagsLoad,
  input wire logic calRun,
  input wire logic [5:0] rxFlags,
  input wire logic [2:0] clkOutSel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic conWr;
  assign conWr = regWrite && regAddr == pwco_pkg::ADDR_CLK_CON;
  property p_kick; regRead && regAddr == pwco_pkg::ADDR_CLK_CON |=> !regRdata[7]; endproperty
  a_kick: assert property (p_kick) else $error("kick bit read as one");
  property p_refuse; conWr && regWdata[7] && !pollTimerEn && !calRun |=> !calRun; endproperty
  a_refuse: assert property (p_refuse) else $error("calibration without timer");
  property p_cal_len; $rose(calRun) |-> ##63 calRun ##1 !calRun; endproperty
  a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
  property p_sel; conWr |-> ##2 clkOutSel == $past(regWdata[4:2], 2); endproperty
  a_sel: assert property (p_sel) else $error("clock out select wrong");
  property p_ext; conWr && regWdata[1:0] == 2'h3 |-> ##2 extBufEnable && refClkAlways && !oscEnable; endproperty
  a_ext: assert property (p_ext) else $error("external buffer pair wrong");
  property p_off; conWr && regWdata[1:0] == 2'h1 |-> ##2 !oscEnable && !extBufEnable; endproperty
  a_off: assert property (p_off) else $error("both-off pair wrong");
  property p_group; rxFlagsLoad |-> rxFlags[2]; endproperty
  a_group: assert property (p_group) else $error("group flag not forced");
  property p_launch; rxFlagsLoad |=> rxLaunch && pollIrq; endproperty
  a_launch: assert property (p_launch) else $error("launch missing after load");
  cover property ($fell(calRun));
  cover property (rxLaunch);
  cover property (pollIrq && !rxLaunch);
endmodule
bind pwco_poll_wake pwco_monitor mon (.mclk, .rstn, .regWrite, .regRead, .pollTimerEn, .regAddr, .regWdata,
  .regRdata, .oscEnable, .extBufEnable, .refClkAlways, .pollIrq, .rxLaunch, .rxFlagsLoad, .calRun, .rxFlags, .clkOutSel);
`default_nettype wire

// >>> pwco_pkg.sv
// Constants, register map and state types for the polling wake and clock-out block
// Operation
// - Wake action field, bits 7:6, picks the mode entered after a polling event.
// - Action 00: signal unmaskable polling interrupt, stay powered down.
// - Action 01: signal unmaskable interrupt, wake and start oscillator or buffer.
// - Action 10: power up to receive; interrupt at event when enabled.
// - Action 11: power up, launch configured receive command once settled; interrupt guaranteed (here a power-down before the launch drops it).
// - Bits 5:4 select receive channel like the frequency selection flags.
// - Bit 3 picks wakeup search at 0, preamble detection at 1.
// - Bits 2:1 select gain step and switch like the gain flags.
// - Bit 0 set replaces frequency, kind and gain flags before launch.
// - When flags are replaced, the sub-command group flag is forced to 1.
// - Writing 1 to clock control bit 7 requests calibration; it reads zero.
// - Calibration runs only with polling timer and oscillator running, else ignored.
// - Bit 6 reads 1 while a calibration is in progress.
// - Bit 5 sets the wake tick to 1 ms or 16 ms.
// - Clock out codes 000..100 give reference, halves, quarter, eighth, four times chip clock.
// - External buffer enable bit 1 acts jointly with oscillator disable bit 0.
// - Wake period is wake count value plus one, times the wake tick.
// - Flag register records events since last read and clears on read.
// - Buffer/oscillator pair decodes to oscillator, both off, always-on reference, external buffer.
// - Clock out codes 101, 110, 111 give twice chip clock, chip clock, bit clock.
package pwco_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h15;
  localparam logic [7:0] ADDR_WAKE_CNT = 8'h16;
  localparam logic [7:0] ADDR_POLL_ACT = 8'h17;
  localparam logic [7:0] ADDR_CLK_CON = 8'h18;

  // Reset values
  localparam logic [7:0] RST_POLL_ACT = 8'h00;
  localparam logic [5:0] RST_CLK_CTL = 6'h04;
  localparam logic [7:0] RST_WAKE_CNT = 8'hFF;

  // Field positions
  localparam int POLL_IRQ_BIT = 3;
  localparam int ACT_MODE_HI = 7;
  localparam int ACT_MODE_LO = 6;
  localparam int ACT_FREQ_HI = 5;
  localparam int ACT_FREQ_LO = 4;
  localparam int ACT_CMD_BIT = 3;
  localparam int ACT_GAIN_HI = 2;
  localparam int ACT_GAIN_LO = 1;
  localparam int ACT_OVR_BIT = 0;
  localparam int CON_KICK_BIT = 7;
  localparam int CON_BUSY_BIT = 6;
  localparam int CTL_LONG_BIT = 5;
  localparam int CTL_SEL_HI = 4;
  localparam int CTL_SEL_LO = 2;
  localparam int CTL_BUF_BIT = 1;
  localparam int CTL_XOD_BIT = 0;

  // Wake action codes
  localparam logic [1:0] ACT_SLEEP = 2'h0;
  localparam logic [1:0] ACT_OSC = 2'h1;
  localparam logic [1:0] ACT_RX = 2'h2;
  localparam logic [1:0] ACT_RX_CMD = 2'h3;

  // Buffer/oscillator pair codes
  localparam logic [1:0] XO_BOTH_OFF = 2'h1;
  localparam logic [1:0] XO_EXT_BUF = 2'h3;

  // Timing
  localparam int MCLK_PERIOD_NS = 50;
  localparam int WAKE_TICK_NS = 1000000;
  localparam int TICK_CYCLES = (WAKE_TICK_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [3:0] LONG_TICK_LAST = 4'hF;
  localparam logic [7:0] CAL_LAST = 8'h3F;
  localparam int PRE_W = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_RX = 2'b01,
    ST_LAUNCH = 2'b10
  } pwco_state_t;

endpackage

// >>> pwco_poll_wake.sv
// Polling timer wake action, calibration request and clock connection control
`timescale 1ns/1ps
`default_nettype none
module pwco_poll_wake #(
  parameter int TICK_CYCLES = pwco_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port from the serial interface decoder
  input wire logic [7:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Status from surrounding logic
  input wire logic pollTimerEn,
  input wire logic oscStable,
  input wire logic rxReady,
  input wire logic enterPowerDown,
  // Wake and power control
  output logic pollIrq,
  output logic awake,
  output logic oscEnable,
  output logic extBufEnable,
  output logic refClkAlways,
  output logic rxPowerUp,
  // Receive command launch
  output logic rxLaunch,
  output logic rxFlagsLoad,
  output logic [5:0] rxFlags,
  // Clock out and calibration
  output logic [2:0] clkOutSel,
  output logic calRun
);

  typedef struct packed {
    logic [7:0] pollAct;
    logic [5:0] clkCtl;
    logic [7:0] wakeCnt;
    logic irqEn;
    logic pollFlag;
    logic [pwco_pkg::PRE_W-1:0] pre;
    logic [3:0] sub;
    logic [7:0] wcnt;
    logic [7:0] calCnt;
    logic calOn;
    pwco_pkg::pwco_state_t state;
    logic awake;
    logic oscEn;
    logic extBuf;
    logic refAlways;
    logic rxPwr;
    logic rxLaunch;
    logic rxFlagsLoad;
    logic [5:0] rxFlags;
    logic pollIrq;
    logic [7:0] rdata;
    logic [2:0] clkOutSel;
    logic oscS1;
    logic oscS2;
  } pwco_regs_t;

  pwco_regs_t s_q;
  pwco_regs_t s_d;

  logic [1:0] mode;
  logic [1:0] xoPair;
  logic tick;
  logic wakeTick;
  logic pollEvent;
  logic wrAct;
  logic wrCon;
  logic calKick;

  assign mode = s_q.pollAct[pwco_pkg::ACT_MODE_HI:pwco_pkg::ACT_MODE_LO];
  assign xoPair = {s_q.clkCtl[pwco_pkg::CTL_BUF_BIT], s_q.clkCtl[pwco_pkg::CTL_XOD_BIT]};
  assign tick = pollTimerEn && (s_q.pre == pwco_pkg::PRE_W'(TICK_CYCLES - 1));
  // Long range stretches each tick over sixteen base ticks
  assign wakeTick = tick && (!s_q.clkCtl[pwco_pkg::CTL_LONG_BIT] || s_q.sub == pwco_pkg::LONG_TICK_LAST);
  assign pollEvent = wakeTick && (s_q.wcnt == s_q.wakeCnt);
  assign wrAct = regWrite && (regAddr == pwco_pkg::ADDR_POLL_ACT);
  assign wrCon = regWrite && (regAddr == pwco_pkg::ADDR_CLK_CON);
  assign calKick = wrCon && regWdata[pwco_pkg::CON_KICK_BIT];

  always_comb
  begin
    s_d = s_q;
    s_d.pollIrq = 1'b0;
    s_d.rxLaunch = 1'b0;
    s_d.rxFlagsLoad = 1'b0;
    // Oscillator status is asynchronous, so two flops come before any use
    s_d.oscS1 = oscStable;
    s_d.oscS2 = s_q.oscS1;

    // Register writes
    if (wrAct)
    begin
      s_d.pollAct = regWdata;
    end
    // Kick bit is a strobe; only the low six bits are stored
    if (wrCon)
    begin
      s_d.clkCtl = regWdata[pwco_pkg::CTL_LONG_BIT:0];
    end
    if (regWrite && regAddr == pwco_pkg::ADDR_WAKE_CNT)
    begin
      s_d.wakeCnt = regWdata;
    end
    if (regWrite && regAddr == pwco_pkg::ADDR_IRQ_EN)
    begin
      s_d.irqEn = regWdata[pwco_pkg::POLL_IRQ_BIT];
    end

    // Register reads
    if (regRead)
    begin
      case (regAddr)
        pwco_pkg::ADDR_IRQ_EN:
        begin
          s_d.rdata = 8'h00;
          s_d.rdata[pwco_pkg::POLL_IRQ_BIT] = s_q.irqEn;
        end
        pwco_pkg::ADDR_IRQ_FLAG:
        begin
          s_d.rdata = 8'h00;
          s_d.rdata[pwco_pkg::POLL_IRQ_BIT] = s_q.pollFlag;
        end
        pwco_pkg::ADDR_WAKE_CNT: s_d.rdata = s_q.wakeCnt;
        pwco_pkg::ADDR_POLL_ACT: s_d.rdata = s_q.pollAct;
        pwco_pkg::ADDR_CLK_CON:
        begin
          s_d.rdata = 8'(s_q.clkCtl);
          s_d.rdata[pwco_pkg::CON_KICK_BIT] = 1'b0;
          s_d.rdata[pwco_pkg::CON_BUSY_BIT] = s_q.calOn;
        end
        default: s_d.rdata = 8'h00;
      endcase
      if (regAddr == pwco_pkg::ADDR_IRQ_FLAG)
      begin
        s_d.pollFlag = 1'b0;
      end
    end

    // Event set wins over a clear-on-read in the same cycle, in every state
    if (pollEvent)
    begin
      s_d.pollFlag = 1'b1;
    end

    // Polling timer: free running while enabled, restarts after each event
    if (!pollTimerEn)
    begin
      s_d.pre = '0;
      s_d.sub = 4'h0;
      s_d.wcnt = 8'h00;
    end
    else if (tick)
    begin
      s_d.pre = '0;
      s_d.sub = s_q.sub + 4'h1;
      if (wakeTick)
      begin
        s_d.sub = 4'h0;
        s_d.wcnt = pollEvent ? 8'h00 : s_q.wcnt + 8'h01;
      end
    end
    else
    begin
      s_d.pre = s_q.pre + pwco_pkg::PRE_W'(1);
    end

    // Calibration request is dropped unless timer and oscillator run
    if (s_q.calOn)
    begin
      s_d.calCnt = s_q.calCnt + 8'h01;
      if (s_q.calCnt == pwco_pkg::CAL_LAST)
      begin
        s_d.calOn = 1'b0;
      end
    end
    else if (calKick && pollTimerEn && s_q.oscEn && s_q.oscS2)
    begin
      s_d.calOn = 1'b1;
      s_d.calCnt = 8'h00;
    end

    // Power-down aborts a pending launch; an event in the same cycle still wakes only from idle
    if (enterPowerDown)
    begin
      s_d.awake = 1'b0;
      s_d.rxPwr = 1'b0;
      s_d.state = pwco_pkg::ST_IDLE;
    end

    // Wake action sequence
    case (s_q.state)
      pwco_pkg::ST_IDLE:
      begin
        if (pollEvent)
        begin
          case (mode)
            pwco_pkg::ACT_SLEEP:
            begin
              s_d.pollIrq = 1'b1;
            end
            pwco_pkg::ACT_OSC:
            begin
              s_d.pollIrq = 1'b1;
              s_d.awake = 1'b1;
            end
            pwco_pkg::ACT_RX:
            begin
              s_d.pollIrq = s_q.irqEn;
              s_d.awake = 1'b1;
              s_d.rxPwr = 1'b1;
            end
            pwco_pkg::ACT_RX_CMD:
            begin
              s_d.awake = 1'b1;
              s_d.rxPwr = 1'b1;
              s_d.state = pwco_pkg::ST_WAIT_RX;
            end
            default:
            begin
              s_d.state = pwco_pkg::ST_IDLE;
            end
          endcase
        end
      end
      pwco_pkg::ST_WAIT_RX:
      begin
        if (rxReady && !enterPowerDown)
        begin
          s_d.state = pwco_pkg::ST_LAUNCH;
          // Flags overwritten one cycle ahead of the launch strobe
          if (s_q.pollAct[pwco_pkg::ACT_OVR_BIT])
          begin
            s_d.rxFlagsLoad = 1'b1;
            s_d.rxFlags = {s_q.pollAct[pwco_pkg::ACT_FREQ_LO], s_q.pollAct[pwco_pkg::ACT_FREQ_HI],
              s_q.pollAct[pwco_pkg::ACT_CMD_BIT],
              1'b1,
              s_q.pollAct[pwco_pkg::ACT_GAIN_LO], s_q.pollAct[pwco_pkg::ACT_GAIN_HI]};
          end
        end
      end
      pwco_pkg::ST_LAUNCH:
      begin
        if (!enterPowerDown)
        begin
          // Launch carries the one interrupt of the sequence; a power-down before it drops the interrupt
          s_d.rxLaunch = 1'b1;
          s_d.pollIrq = 1'b1;
          s_d.state = pwco_pkg::ST_IDLE;
        end
      end
      default:
      begin
        s_d.state = pwco_pkg::ST_IDLE;
      end
    endcase

    // Clock source decode from the buffer/oscillator pair
    s_d.oscEn = s_d.awake && xoPair != pwco_pkg::XO_BOTH_OFF && xoPair != pwco_pkg::XO_EXT_BUF;
    s_d.extBuf = s_d.awake && xoPair == pwco_pkg::XO_EXT_BUF;
    s_d.refAlways = s_q.clkCtl[pwco_pkg::CTL_BUF_BIT];
    s_d.clkOutSel = s_q.clkCtl[pwco_pkg::CTL_SEL_HI:pwco_pkg::CTL_SEL_LO];
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.pollAct <= pwco_pkg::RST_POLL_ACT;
      s_q.clkCtl <= pwco_pkg::RST_CLK_CTL;
      s_q.wakeCnt <= pwco_pkg::RST_WAKE_CNT;
      s_q.state <= pwco_pkg::ST_IDLE;
      s_q.awake <= 1'b1;
      s_q.oscEn <= 1'b1;
      s_q.clkOutSel <= pwco_pkg::RST_CLK_CTL[pwco_pkg::CTL_SEL_HI:pwco_pkg::CTL_SEL_LO];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign regRdata = s_q.rdata;
  assign pollIrq = s_q.pollIrq;
  assign awake = s_q.awake;
  assign oscEnable = s_q.oscEn;
  assign extBufEnable = s_q.extBuf;
  assign refClkAlways = s_q.refAlways;
  assign rxPowerUp = s_q.rxPwr;
  assign rxLaunch = s_q.rxLaunch;
  assign rxFlagsLoad = s_q.rxFlagsLoad;
  assign rxFlags = s_q.rxFlags;
  assign clkOutSel = s_q.clkOutSel;
  assign calRun = s_q.calOn;

endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the polling wake block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic rstn, pollTimerEn, oscStable, rxReady, enterPowerDown;
  wire logic regWrite, regRead;
  wire logic [7:0] regAddr, regWdata, regRdata;
  wire logic pollIrq, awake, oscEnable, extBufEnable, refClkAlways, rxPowerUp, rxLaunch, rxFlagsLoad, calRun;
  wire logic [5:0] rxFlags;
  wire logic [2:0] clkOutSel;
  wire logic [5:0] outs = {awake, calRun, rxLaunch, rxFlagsLoad, rxPowerUp, pollIrq};
  integer seed = 24692;
  int n_mismatch = 0;
  int n_checks = 0;
  pwco_poll_wake #(.TICK_CYCLES(TK)) dut (.mclk, .rstn, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
    .pollTimerEn, .oscStable, .rxReady, .enterPowerDown, .pollIrq, .awake, .oscEnable, .extBufEnable,
    .refClkAlways, .rxPowerUp, .rxLaunch, .rxFlagsLoad, .rxFlags, .clkOutSel, .calRun);
  pwco_host_model host (.mclk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata);
  initial forever #25 mclk = ~mclk;
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(16'(d), exp);
  endtask
  task automatic count_until(input int k, input logic v, output int t);
    t = 0;
    while (outs[k] !== v && t < 1000)
    begin
      t++;
      @(posedge mclk) #1;
    end
    if (outs[k] !== v)
    begin
      n_mismatch++;
      $display("unexpected at %0t: count ran out", $time);
      wrap_up();
    end
  endtask
  task automatic wait_hi(input int k, input int lim);
    for (int i = 0; i < lim && outs[k] !== 1'b1; i++)
      @(posedge mclk) #1;
    if (outs[k] !== 1'b1)
    begin
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up();
    end
  endtask
  function automatic logic [15:0] pair_exp(input logic [1:0] p);
    return {13'h0000, !p[0], p[1] & p[0], p[1]};
  endfunction
  function automatic logic [15:0] flag_exp(input logic [7:0] a);
    return {10'h000, a[4], a[5], a[3], 1'b1, a[1], a[2]};
  endfunction
  initial
  begin
    logic [7:0] a;
    logic [7:0] n;
    int t;
    {rstn, pollTimerEn, oscStable, rxReady, enterPowerDown} = 5'h04;
    repeat (4) @(posedge mclk);
    #1 rstn = 1'b1;
    chk(16'(clkOutSel), 16'h0001);
    rdc(8'h17, 16'h0000);
    rdc(8'h18, 16'h0004);
    rdc(8'h16, 16'h00FF);
    rdc(8'h33, 16'h0000);
    // Kick rides along with every select; timer is off so it must be dropped
    for (int k = 0; k < 8; k++)
    begin
      host.wr(8'h18, {3'b100, 3'(k), 2'(k)});
      @(posedge mclk) #1;
      chk(16'(clkOutSel), 16'(k));
      chk({13'h0000, oscEnable, extBufEnable, refClkAlways}, pair_exp(2'(k)));
      chk(16'(calRun), 16'h0000);
      rdc(8'h18, 16'(4 * k + (k & 3)));
    end
    host.wr(8'h18, 8'h04);
    pollTimerEn = 1'b1;
    host.wr(8'h18, 8'h84);
    wait_hi(4, 4);
    rdc(8'h18, 16'h0044);
    count_until(4, 1'b0, t);
    // Three cycles went to the status read
    chk(16'(t), 16'h003D);
    for (int k = 0; k < 2; k++)
    begin
      n = 8'($random(seed)) & 8'h07;
      pollTimerEn = 1'b0;
      host.wr(8'h16, n);
      host.wr(8'h18, {2'b00, 1'(k), 5'h04});
      pollTimerEn = 1'b1;
      wait_hi(0, 600);
      @(posedge mclk) #1;
      count_until(0, 1'b1, t);
      chk(16'(t + 1), 16'((n + 1) * TK * (k * 15 + 1)));
    end
    pollTimerEn = 1'b0;
    rdc(8'h15, 16'h0008);
    rdc(8'h15, 16'h0000);
    host.wr(8'h18, 8'h04);
    for (int m = 0; m < 4; m++)
    begin
      pollTimerEn = 1'b0;
      enterPowerDown = 1'b1;
      @(posedge mclk) #1;
      enterPowerDown = 1'b0;
      a = {2'(m), 6'($random(seed)) | 6'h01};
      host.wr(8'h17, a);
      // Interrupt enable off for the unmaskable modes
      host.wr(8'h14, {4'h0, 1'(m / 2), 3'h0});
      pollTimerEn = 1'b1;
      wait_hi(m / 2, 100);
      repeat (2) @(posedge mclk) #1;
      chk(16'(awake), 16'(m != 0));
      chk(16'(rxPowerUp), 16'(m / 2));
      if (m == 3)
      begin
        rxReady = 1'b1;
        wait_hi(2, 50);
        chk(16'(rxFlags), flag_exp(a));
        @(posedge mclk) #1;
        chk({14'h0000, rxLaunch, pollIrq}, 16'h0003);
        rxReady = 1'b0;
      end
    end
    // Reset again in mid-run
    pollTimerEn = 1'b0;
    rstn = 1'b0;
    repeat (4) @(posedge mclk) #1;
    rstn = 1'b1;
    chk({10'h000, outs}, 16'h0020);
    rdc(8'h17, 16'h0000);
    wrap_up();
  end
endmodule
`default_nettype wire
